// file: hdl/tcs_map.svh
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH
// Overview of operation
// - Enable high calibrates, low transfers codes
// - Select gates serializer or calibration per block
// - Block shifts 32-bit code, series then parallel
// - Bank latches serial code on load enable
// - Blocks start calibrating independently
// - Clear resets every unselected block not mid-calibration
// - Pseudo-differential output uses inverted twin driver
// - Power-up calibrates and loads before user mode
`define TCS_NUM_BLOCKS 8
`define TCS_NUM_BANKS 8
`define TCS_CODE_BITS 32
`define TCS_HALF_BITS 16
`define TCS_CAL_CYCLES 1000
`define TCS_CNT_BITS 10
`define TCS_RS_RESET 16'h8000
`define TCS_RT_RESET 16'h8000
`endif

// file: hdl/tcs_pkg.sv
package tcs_pkg;
   typedef enum logic [1:0] {TCS_UNCAL, TCS_CAL, TCS_DONE} tcs_blk_state_t;
   typedef logic [31:0] tcs_code_t;
endpackage

// file: hdl/tcs_sequencer.sv
`timescale 1ns/10ps
`include "tcs_map.svh"
module tcs_sequencer (
   // System clock side
   input wire logic clk,
   input wire logic rst,
   // Link from user control logic, on its calibration clock
   input wire logic cal_ctrl_clock,
   input wire logic cal_ctrl_rst,
   input wire logic global_cal_enable,
   input wire logic [7:0] block_select_lines,
   input wire logic cal_clear_n,
   input wire logic [7:0] bank_parallel_load,
   // Per-block source of each bank's code
   input wire logic [23:0] bank_source_sel,
   // Comparator results per block, one step per cycle
   input wire logic [7:0] cal_compare_up,
   // Power-up calibration request and user-mode release
   input wire logic powerup_start,
   output logic user_mode,
   // Pseudo-differential driver pair for each bank
   input wire logic [7:0] pdiff_data,
   output logic [7:0] pdiff_out_p,
   output logic [7:0] pdiff_out_n,
   // Calibrated codes and status, system clock side
   output tcs_pkg::tcs_code_t bank_code [8],
   output logic [7:0] bank_busy,
   output logic [7:0] block_calibrated
);
   import tcs_pkg::*;

   // ******************************************
   // Per-block calibration and serializer
   // ******************************************
   logic [31:0] cal_code_ff [8];
   logic [31:0] nxt_cal_code [8];
   logic [9:0] cal_cnt_ff [8];
   logic [9:0] nxt_cal_cnt [8];
   tcs_blk_state_t blk_st_ff [8];
   tcs_blk_state_t nxt_blk_st [8];
   logic [7:0] ser_bit_ff;
   logic [7:0] nxt_ser_bit;
   logic [7:0] sel_q_ff;
   logic [7:0] nxt_sel_q;
   logic pu_active_ff;
   logic nxt_pu_active;
   // Comparator is analog and free-running, so it is synchronised first
   logic [7:0] cmp_s1_ff;
   logic [7:0] cmp_s2_ff;

   genvar gb;
   generate
      for (gb = 0; gb < `TCS_NUM_BLOCKS; gb++) begin : g_blk
         logic en;
         logic cal_mode;
         logic pu_cal;
         // Power-up drives each block through exactly one calibration, no extra step
         assign pu_cal = pu_active_ff && (blk_st_ff[gb] != TCS_DONE);
         assign en = block_select_lines[gb] | pu_cal;
         assign cal_mode = global_cal_enable | pu_cal;
         always_comb begin
            nxt_cal_code[gb] = cal_code_ff[gb];
            nxt_cal_cnt[gb] = cal_cnt_ff[gb];
            nxt_blk_st[gb] = blk_st_ff[gb];
            nxt_ser_bit[gb] = ser_bit_ff[gb];
            // clear hits every unselected block that is not calibrating
            if (!cal_clear_n && !en && blk_st_ff[gb] != TCS_CAL) begin
               nxt_cal_code[gb] = {`TCS_RT_RESET, `TCS_RS_RESET};
               nxt_cal_cnt[gb] = '0;
               nxt_blk_st[gb] = TCS_UNCAL;
            end else if (en && cal_mode) begin
               // each block starts on its own select
               nxt_blk_st[gb] = TCS_CAL;
               // Simple successive step toward the comparator target
               if (cmp_s2_ff[gb]) begin
                  nxt_cal_code[gb] = cal_code_ff[gb] + 32'h0001_0001;
               end else begin
                  nxt_cal_code[gb] = cal_code_ff[gb] - 32'h0001_0001;
               end
               if (cal_cnt_ff[gb] == 10'(`TCS_CAL_CYCLES - 1)) begin
                  nxt_blk_st[gb] = TCS_DONE;
               end else begin
                  nxt_cal_cnt[gb] = cal_cnt_ff[gb] + 10'h001;
               end
            end else if (en) begin
               // rotate 32-bit code out; LSB first, one per clock
               nxt_ser_bit[gb] = cal_code_ff[gb][0];
               nxt_cal_code[gb] = {cal_code_ff[gb][0], cal_code_ff[gb][31:1]};
            end
         end
         always_ff @(posedge cal_ctrl_clock) begin
            if (cal_ctrl_rst) begin
               cal_code_ff[gb] <= {`TCS_RT_RESET, `TCS_RS_RESET};
               cal_cnt_ff[gb] <= '0;
               blk_st_ff[gb] <= TCS_UNCAL;
               ser_bit_ff[gb] <= 1'b0;
            end else begin
               cal_code_ff[gb] <= nxt_cal_code[gb];
               cal_cnt_ff[gb] <= nxt_cal_cnt[gb];
               blk_st_ff[gb] <= nxt_blk_st[gb];
               ser_bit_ff[gb] <= nxt_ser_bit[gb];
            end
         end
      end
   endgenerate

   // ******************************************
   // Power-up calibration
   // ******************************************
   // runs one full calibration then enters user mode
   logic pu_s1_ff;
   logic pu_s2_ff;
   logic user_mode_ff;
   logic nxt_user_mode;
   always_comb begin
      nxt_pu_active = pu_active_ff;
      nxt_user_mode = user_mode_ff;
      nxt_sel_q = (global_cal_enable || pu_active_ff) ? 8'h00 : block_select_lines;
      if (pu_s2_ff && !pu_active_ff && !user_mode_ff) begin
         nxt_pu_active = 1'b1;
      end else if (pu_active_ff && blk_st_ff[0] == TCS_DONE) begin
         nxt_pu_active = 1'b0;
         nxt_user_mode = 1'b1;
      end
   end
   always_ff @(posedge cal_ctrl_clock) begin
      if (cal_ctrl_rst) begin
         pu_s1_ff <= 1'b0;
         pu_s2_ff <= 1'b0;
         cmp_s1_ff <= 8'h00;
         cmp_s2_ff <= 8'h00;
         pu_active_ff <= 1'b0;
         user_mode_ff <= 1'b0;
         sel_q_ff <= 8'h00;
      end else begin
         pu_s1_ff <= powerup_start;
         pu_s2_ff <= pu_s1_ff;
         cmp_s1_ff <= cal_compare_up;
         cmp_s2_ff <= cmp_s1_ff;
         pu_active_ff <= nxt_pu_active;
         user_mode_ff <= nxt_user_mode;
         sel_q_ff <= nxt_sel_q;
      end
   end
   assign user_mode = user_mode_ff;

   // ******************************************
   // Per-bank shift and parallel load
   // ******************************************
   logic [31:0] bank_sh_ff [8];
   logic [31:0] nxt_bank_sh [8];
   logic [31:0] bank_par_ff [8];
   logic [31:0] nxt_bank_par [8];
   logic [7:0] par_tog_ff;
   logic [7:0] nxt_par_tog;
   genvar gk;
   generate
      for (gk = 0; gk < `TCS_NUM_BANKS; gk++) begin : g_bank
         logic [2:0] src;
         assign src = bank_source_sel[gk*3 +: 3];
         always_comb begin
            nxt_bank_sh[gk] = bank_sh_ff[gk];
            nxt_bank_par[gk] = bank_par_ff[gk];
            nxt_par_tog[gk] = par_tog_ff[gk];
            // Serial bit arrives one cycle after the block shifted it
            if (sel_q_ff[src]) begin
               nxt_bank_sh[gk] = {ser_bit_ff[src], bank_sh_ff[gk][31:1]};
            end
            // parallel load; held by user logic
            if (bank_parallel_load[gk] || pu_active_ff) begin
               nxt_bank_par[gk] = pu_active_ff ? cal_code_ff[src] : bank_sh_ff[gk];
               nxt_par_tog[gk] = ~par_tog_ff[gk];
            end
         end
         always_ff @(posedge cal_ctrl_clock) begin
            if (cal_ctrl_rst) begin
               bank_sh_ff[gk] <= '0;
               bank_par_ff[gk] <= {`TCS_RT_RESET, `TCS_RS_RESET};
               par_tog_ff[gk] <= 1'b0;
            end else begin
               bank_sh_ff[gk] <= nxt_bank_sh[gk];
               bank_par_ff[gk] <= nxt_bank_par[gk];
               par_tog_ff[gk] <= nxt_par_tog[gk];
            end
         end
      end
   endgenerate

   // ******************************************
   // Crossing to system clock
   // ******************************************
   // Codes move with a toggle; the bank word holds until the next load
   logic [7:0] tog_s1_ff;
   logic [7:0] tog_s2_ff;
   logic [7:0] tog_s3_ff;
   logic [7:0] ld_s1_ff;
   logic [7:0] ld_s2_ff;
   logic [7:0] cb_s1_ff;
   logic [7:0] cb_s2_ff;
   logic [31:0] code_ff [8];
   logic [31:0] nxt_code [8];
   logic [7:0] done_vec;
   logic [7:0] pd_p_ff;
   logic [7:0] pd_n_ff;
   logic [7:0] nxt_pd_p;
   logic [7:0] nxt_pd_n;
   genvar gc;
   generate
      for (gc = 0; gc < 8; gc++) begin : g_cdc
         assign done_vec[gc] = (blk_st_ff[gc] == TCS_DONE);
         assign nxt_code[gc] = (tog_s2_ff[gc] != tog_s3_ff[gc]) ? bank_par_ff[gc] : code_ff[gc];
      end
   endgenerate
   always_comb begin
      nxt_pd_p = pdiff_data;
      nxt_pd_n = ~pdiff_data;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         tog_s1_ff <= '0;
         tog_s2_ff <= '0;
         tog_s3_ff <= '0;
         ld_s1_ff <= '0;
         ld_s2_ff <= '0;
         cb_s1_ff <= '0;
         cb_s2_ff <= '0;
         pd_p_ff <= '0;
         pd_n_ff <= 8'hff;
         for (int i = 0; i < 8; i++) begin
            code_ff[i] <= {`TCS_RT_RESET, `TCS_RS_RESET};
         end
      end else begin
         tog_s1_ff <= par_tog_ff;
         tog_s2_ff <= tog_s1_ff;
         tog_s3_ff <= tog_s2_ff;
         ld_s1_ff <= bank_parallel_load;
         ld_s2_ff <= ld_s1_ff;
         cb_s1_ff <= done_vec;
         cb_s2_ff <= cb_s1_ff;
         pd_p_ff <= nxt_pd_p;
         pd_n_ff <= nxt_pd_n;
         code_ff <= nxt_code;
      end
   end
   assign bank_code = code_ff;
   // flag banks whose I/O must stay quiet
   assign bank_busy = ld_s2_ff;
   assign block_calibrated = cb_s2_ff;
   assign pdiff_out_p = pd_p_ff;
   assign pdiff_out_n = pd_n_ff;
endmodule

// file: verif/tcs_ctrl_model.sv
`timescale 1ns/10ps
// ***
// User control logic
// ***
module tcs_ctrl_model (
   // Link clock
   input wire logic cal_ctrl_clock,
   // Controls, idle levels at start
   // idle levels
   output logic global_cal_enable = 1'b0,
   output logic [7:0] block_select_lines = 8'h00,
   output logic cal_clear_n = 1'b1,
   output logic [7:0] bank_parallel_load = 8'h00
);
   task automatic step(input int n);
      repeat (n) @(posedge cal_ctrl_clock);
   endtask
   // Stray clear; a calibrating block must ignore it
   task automatic clear_pulse(input int n);
      step(n);
      cal_clear_n <= 1'b0;
      step(1);
      cal_clear_n <= 1'b1;
   endtask
   // Calibrate one block, shift its code, load banks
   task automatic run(input int b, input logic [7:0] banks);
      step(1);
      global_cal_enable <= 1'b1;
      step(1);
      cal_clear_n <= 1'b0;
      step(1);
      cal_clear_n <= 1'b1;
      block_select_lines[b] <= 1'b1;
      step(1000);
      block_select_lines[b] <= 1'b0;
      step(1);
      global_cal_enable <= 1'b0;
      step(2);
      block_select_lines[b] <= 1'b1;
      step(32);
      block_select_lines[b] <= 1'b0;
      step(1);
      bank_parallel_load <= banks;
      step(1);
      bank_parallel_load <= 8'h00;
   endtask
endmodule

// file: verif/tcs_sequencer_chk.sv
`timescale 1ns/10ps
// ***
// Port checker
// ***
module tcs_sequencer_chk (
   // Clock, reset
   input wire logic clk,
   input wire logic rst,
   // Watched ports
   input wire logic global_cal_enable,
   input wire logic [7:0] bank_parallel_load,
   input wire logic [7:0] pdiff_data,
   input wire logic [7:0] pdiff_out_p,
   input wire logic [7:0] pdiff_out_n,
   input wire logic user_mode,
   input tcs_pkg::tcs_code_t bank_code [8],
   input wire logic [7:0] bank_busy,
   input wire logic [7:0] block_calibrated
);
   import tcs_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Driver pair
   property p_inv; pdiff_out_n == ~pdiff_out_p; endproperty
   a_inv: assert property (p_inv) else $error("pair not inverted");
   property p_lat; !$past(rst) |-> pdiff_out_p == $past(pdiff_data); endproperty
   a_lat: assert property (p_lat) else $error("pair lags data");
   // Release state, user mode sticks
   property p_rel; $fell(rst) |-> !user_mode && bank_busy == 8'h00 && bank_code[0] == 32'h80008000; endproperty
   a_rel: assert property (p_rel) else $error("bad release state");
   property p_um; user_mode |=> user_mode; endproperty
   a_um: assert property (p_um) else $error("user mode lost");
   // Load sync; codes only move under load
   property p_busy; $stable(bank_parallel_load) [*3] |-> bank_busy == bank_parallel_load; endproperty
   a_busy: assert property (p_busy) else $error("busy not load");
   property p_code0; (!bank_busy[0] && $past(user_mode, 5)) [*3] |-> $stable(bank_code[0]); endproperty
   a_code0: assert property (p_code0) else $error("code 0 moved");
   property p_code7;
      $past(user_mode, 5) && !bank_busy[7] && !$past(bank_busy[7]) && !$past(bank_busy[7], 2)
         |-> $stable(bank_code[7]);
   endproperty
   a_code7: assert property (p_code7) else $error("code 7 moved");
   // Done only in calibrate mode
   property p_cal; user_mode && (block_calibrated & ~$past(block_calibrated)) != 8'h00 |-> global_cal_enable; endproperty
   a_cal: assert property (p_cal) else $error("done outside cal");
   // Main scenarios
   c_load: cover property ($rose(bank_busy[0]));
   c_cal: cover property ($rose(block_calibrated[5]));
   c_um: cover property ($rose(user_mode));
endmodule
bind tcs_sequencer tcs_sequencer_chk CHK (.clk, .rst, .global_cal_enable, .bank_parallel_load, .pdiff_data,
   .pdiff_out_p, .pdiff_out_n, .user_mode, .bank_code, .bank_busy, .block_calibrated);

// file: verif/test_tcs_sequencer.sv
`timescale 1ns/10ps
// ***
// Testbench
// ***
module test_tcs_sequencer;
   import tcs_pkg::*;
   typedef struct {int blk; logic up; int bank; logic clr; logic [7:0] pd;} tcs_row_t;
   logic clk = 1'b0, cal_ctrl_clock = 1'b0, rst = 1'b1, cal_ctrl_rst = 1'b1, powerup_start = 1'b0;
   logic global_cal_enable, cal_clear_n, user_mode;
   logic [7:0] block_select_lines, bank_parallel_load, pdiff_out_p, pdiff_out_n, bank_busy, block_calibrated;
   logic [7:0] cal_compare_up = 8'h00, pdiff_data = 8'h00;
   logic [23:0] bank_source_sel = 24'h000000;
   tcs_code_t bank_code [8];
   int num_errors = 0, checks = 0;
   // Block, count up, bank, stray clear, pair data
   tcs_row_t rows [3] = '{'{0, 1, 2, 0, 8'ha5}, '{5, 0, 0, 1, 8'h3c}, '{7, 1, 7, 0, 8'hff}};
   // Clocks; 2 ns offset keeps clk rising edges off cal_ctrl_clock edges
   always #5 clk = ~clk;
   initial #2 forever #24 cal_ctrl_clock = ~cal_ctrl_clock;
   tcs_sequencer DUT (.clk, .rst, .cal_ctrl_clock, .cal_ctrl_rst, .global_cal_enable, .block_select_lines,
      .cal_clear_n, .bank_parallel_load, .bank_source_sel, .cal_compare_up, .powerup_start, .user_mode,
      .pdiff_data, .pdiff_out_p, .pdiff_out_n, .bank_code, .bank_busy, .block_calibrated);
   tcs_ctrl_model PM (.cal_ctrl_clock, .global_cal_enable, .block_select_lines, .cal_clear_n, .bank_parallel_load);
   // Compare helpers
   task automatic cmp_code(input tcs_code_t got, input tcs_code_t exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: code %h not %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bits(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: bits %h not %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Link domain reset
   initial begin
      repeat (3) @(posedge cal_ctrl_clock);
      cal_ctrl_rst <= 1'b0;
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      #1;
      cmp_code(bank_code[4], 32'h80008000);
      cmp_bits(pdiff_out_n, 8'hff);
      $display("reset test done");
      @(posedge clk);
      cal_compare_up <= 8'hff;
      powerup_start <= 1'b1;
      for (int i = 0; i < 12000 && user_mode !== 1'b1; i++)
         @(posedge clk);
      cmp_bits({7'h00, user_mode}, 8'h01);
      repeat (4) @(posedge clk);
      cmp_code(bank_code[3], 32'h83e883e8);
      $display("power-up test done");
      foreach (rows[r]) begin
         @(posedge clk);
         cal_compare_up <= rows[r].up ? 8'hff : 8'h00;
         bank_source_sel[rows[r].bank * 3 +: 3] <= rows[r].blk[2:0];
         pdiff_data <= rows[r].pd;
         fork
            PM.run(rows[r].blk, 8'h01 << rows[r].bank);
            if (rows[r].clr) PM.clear_pulse(300);
         join
         repeat (8) @(posedge clk);
         cmp_code(bank_code[rows[r].bank], rows[r].up ? 32'h83e883e8 : 32'h7c187c18);
         cmp_bits(block_calibrated & (8'h01 << rows[r].blk), 8'h01 << rows[r].blk);
         cmp_bits(pdiff_out_p, rows[r].pd);
         $display("row %0d done", r);
      end
      results();
   end
   // Watchdog
   initial begin
      #600000;
      num_errors++;
      $display("unexpected at %0t: watchdog", $time);
      results();
   end
endmodule
